// >>> hw/ppom_port.sv
// Purpose: eight-pin bidirectional port with peripheral overrides
// Assumes: single clock, synchronous reset, pads resolved outside
// Notes: pad controls are registered; reset tristates on the next edge
//
// What this block does
// R1 - sleep clamp grounds digital input
// R2 - enabled interrupt pins escape the clamp
// R3 - flag high interrupt pins on wake
// R4 - default pull-up when bits equal 010
// R5 - pull-up override value wins when enabled
// R6 - driver enable from override or direction
// R7 - direction override value drives enable
// R8 - pad value from override or output bit
// R9 - override value wins over output bit
// R10 - toggle override inverts output bit
// R11 - input enable from override or sleep
// R12 - input override value wins over state
// R13 - alternate input tapped before synchronizer
// R14 - strobes per port, clamp and pull-up off shared, rest per pin
// R15 - peripherals supply their own override signals
// R16 - inputs stay enabled outside deep sleep
// R17 - pull-up off during reset
// R18 - all pins feed pin change sources
// R19 - bit 4 serial clock and timer16 count
// R20 - bit 5 serial data out, timer16 B
// R21 - bit 6 serial data in, timer16 A
// R22 - bit 7 timer8 B, capture; bit 3 count
// R23 - direction one means output
// R24 - pin write of one toggles output
// R25 - pins tristate under reset
// R26 - clamped input reads zero

`timescale 1ns/1ns

module ppom_port
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [7:0] reg_write_data,
   input wire logic dir_write,
   input wire logic out_write,
   input wire logic pin_write,
   input wire logic sleep_clamp,
   input wire logic pullup_global_off,
   input wire ppom_pkg::ppom_ovr_t [7:0] ovr_in,
   input wire logic [7:0] ext_int_en,
   input wire logic [7:0] ext_int_edge_mode,
   input wire logic [1:0] usi_wire_mode,
   input wire logic usi_data_out_3w,
   input wire logic usi_sda_out,
   input wire logic usi_scl_hold,
   input wire logic timer16_cmp_a_en,
   input wire logic timer16_cmp_a_out,
   input wire logic timer16_cmp_b_en,
   input wire logic timer16_cmp_b_out,
   input wire logic timer8_cmp_b_en,
   input wire logic timer8_cmp_b_out,
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe_n,
   output logic [7:0] pad_pullup_en,
   output logic [7:0] dir_bit,
   output logic [7:0] out_bit,
   output logic [7:0] pin_in_bit,
   output logic [7:0] alt_func_input,
   output logic [7:0] pin_change_src,
   output logic usi_clock_3w,
   output logic usi_clock_2w,
   output logic usi_data_in_3w,
   output logic usi_sda_in,
   output logic timer8_count_src,
   output logic timer16_count_src,
   output logic timer16_capture_in,
   output logic [7:0] ext_int_wake_flag
);

   logic usi_3w;
   logic usi_2w;
   logic sleep_prev_reg;
   logic wake_release;
   logic [7:0] wake_hit;
   logic [7:0] wake_flag_next;
   ppom_pkg::ppom_ovr_t map_ovr [8];
   ppom_pkg::ppom_ovr_t [7:0] ovr_merged;
   logic [7:0] in_ovr_en;

   // peripheral overrides beat the generic bundle where both claim a pin
   function automatic ppom_pkg::ppom_ovr_t merge_ovr(
      input ppom_pkg::ppom_ovr_t gen,
      input ppom_pkg::ppom_ovr_t map);
      ppom_pkg::ppom_ovr_t res;
      res.pullup_ovr_en = gen.pullup_ovr_en | map.pullup_ovr_en;
      res.pullup_ovr_val = map.pullup_ovr_en ? map.pullup_ovr_val
         : gen.pullup_ovr_val;
      res.dir_ovr_en = gen.dir_ovr_en | map.dir_ovr_en;
      res.dir_ovr_val = map.dir_ovr_en ? map.dir_ovr_val : gen.dir_ovr_val;
      res.port_value_ovr_en = gen.port_value_ovr_en | map.port_value_ovr_en;
      res.port_value_ovr_val = map.port_value_ovr_en
         ? map.port_value_ovr_val : gen.port_value_ovr_val;
      res.port_toggle_ovr_en = gen.port_toggle_ovr_en
         | map.port_toggle_ovr_en;
      res.input_en_ovr_en = gen.input_en_ovr_en | map.input_en_ovr_en;
      res.input_en_ovr_val = map.input_en_ovr_en ? map.input_en_ovr_val
         : gen.input_en_ovr_val;
      return res;
   endfunction

   assign usi_3w = usi_wire_mode == ppom_pkg::USI_MODE_3W;
   assign usi_2w = usi_wire_mode[ppom_pkg::USI_MODE_2W_BIT];

   // pins below the serial clock carry inputs only
   genvar k;
   generate
      for (k = 0; k < ppom_pkg::PIN_USI_CLK; k = k + 1)
      begin : g_plain
         assign map_ovr[k] = '{default: 1'h0};
      end
   endgenerate

   // two-wire clock: open drain, low while stretched or written low
   assign map_ovr[ppom_pkg::PIN_USI_CLK] = '{
      dir_ovr_en: usi_2w,
      dir_ovr_val: usi_scl_hold
         | (dir_bit[ppom_pkg::PIN_USI_CLK]
         & ~out_bit[ppom_pkg::PIN_USI_CLK]),
      port_value_ovr_en: usi_2w,
      default: 1'h0}; // R19

   // three-wire data out takes priority over compare B
   assign map_ovr[ppom_pkg::PIN_USI_DO] = '{
      port_value_ovr_en: usi_3w | timer16_cmp_b_en,
      port_value_ovr_val: usi_3w ? usi_data_out_3w : timer16_cmp_b_out,
      default: 1'h0}; // R20

   // two-wire data: open drain, released while both data bits are high
   assign map_ovr[ppom_pkg::PIN_USI_DI] = '{
      dir_ovr_en: usi_2w,
      dir_ovr_val: dir_bit[ppom_pkg::PIN_USI_DI]
         & ~(usi_sda_out & out_bit[ppom_pkg::PIN_USI_DI]),
      port_value_ovr_en: usi_2w | timer16_cmp_a_en,
      port_value_ovr_val: ~usi_2w & timer16_cmp_a_out,
      default: 1'h0}; // R21

   assign map_ovr[ppom_pkg::PIN_CAPTURE] = '{
      port_value_ovr_en: timer8_cmp_b_en,
      port_value_ovr_val: timer8_cmp_b_out,
      default: 1'h0}; // R22

   // write strobes fan out to every pin, clamp and pull-up off too
   generate
      for (k = 0; k < ppom_pkg::NUM_PINS; k = k + 1)
      begin : g_pin
         assign ovr_merged[k] = merge_ovr(ovr_in[k], map_ovr[k]); // R15
         assign in_ovr_en[k] = ovr_merged[k].input_en_ovr_en;

         ppom_pin_cell u_cell
         (
            .clock(clock),
            .reset_n(reset_n),
            .ce(ce),
            .wdata(reg_write_data[k]),
            .dir_write(dir_write), // R14
            .out_write(out_write),
            .pin_write(pin_write),
            .sleep_clamp(sleep_clamp), // R14
            .pullup_global_off(pullup_global_off),
            .ext_int_en(ext_int_en[k]),
            .ovr(ovr_merged[k]),
            .pad_in(pad_in[k]),
            .dir_bit(dir_bit[k]),
            .out_bit(out_bit[k]),
            .pin_in_bit(pin_in_bit[k]),
            .alt_in(alt_func_input[k]),
            .pad_out(pad_out[k]),
            .pad_oe_n(pad_oe_n[k]),
            .pullup_en(pad_pullup_en[k])
         );
      end
   endgenerate

   // peripheral taps come straight from the per-pin input flops
   assign pin_change_src = alt_func_input; // R18
   assign usi_clock_3w = alt_func_input[ppom_pkg::PIN_USI_CLK]; // R19
   assign usi_clock_2w = alt_func_input[ppom_pkg::PIN_USI_CLK];
   assign timer16_count_src = alt_func_input[ppom_pkg::PIN_USI_CLK];
   assign usi_data_in_3w = alt_func_input[ppom_pkg::PIN_USI_DI]; // R21
   assign usi_sda_in = alt_func_input[ppom_pkg::PIN_USI_DI];
   assign timer16_capture_in = alt_func_input[ppom_pkg::PIN_CAPTURE]; // R22
   assign timer8_count_src = alt_func_input[ppom_pkg::PIN_T8_SRC];

   // clamp release looks like an edge to a disabled interrupt pin
   assign wake_release = sleep_prev_reg & ~sleep_clamp;
   assign wake_hit = {ppom_pkg::NUM_PINS{wake_release}} & pad_in
      & ext_int_edge_mode & ~ext_int_en; // R3
   assign wake_flag_next = ce ? wake_hit : ext_int_wake_flag;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         sleep_prev_reg <= ppom_pkg::SYNC_RESET;
         ext_int_wake_flag <= {ppom_pkg::NUM_PINS{ppom_pkg::SYNC_RESET}};
      end
      else
      begin
         sleep_prev_reg <= ce ? sleep_clamp : sleep_prev_reg;
         ext_int_wake_flag <= wake_flag_next; // R3
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   AST_WAKE_FLAG: assert property ( // R3
      $past(ce) && $past(reset_n) && $past(sleep_prev_reg)
      && !$past(sleep_clamp)
      |-> ext_int_wake_flag == ($past(pad_in) & $past(ext_int_edge_mode)
      & ~$past(ext_int_en)))
      else $error("wake flags do not match high edge pins");

   AST_NO_WAKE_IN_SLEEP: assert property ( // R3
      $past(ce) && $past(reset_n) && $past(sleep_clamp)
      |-> ext_int_wake_flag == 8'h00)
      else $error("wake flag raised while still clamped");

   AST_PIN_CHANGE: assert property ( // R18
      $past(ce) && $past(reset_n) && !$past(sleep_clamp)
      && $past(in_ovr_en) == 8'h00
      |-> pin_change_src == $past(pad_in))
      else $error("pin change sources detached from inputs");

   AST_DO_PRIORITY: assert property ( // R20
      $past(ce) && $past(reset_n) && $past(usi_wire_mode)
      == ppom_pkg::USI_MODE_3W && !$past(ovr_in[ppom_pkg::PIN_USI_DO]
      .port_value_ovr_en) |-> pad_out[ppom_pkg::PIN_USI_DO]
      == $past(usi_data_out_3w))
      else $error("three-wire data out not on bit 5");

   AST_CMP_A: assert property ( // R21
      $past(ce) && $past(reset_n) && $past(timer16_cmp_a_en)
      && !$past(usi_2w)
      |-> pad_out[ppom_pkg::PIN_USI_DI] == $past(timer16_cmp_a_out))
      else $error("compare A not on bit 6");

   AST_CMP8_B: assert property ( // R22
      $past(ce) && $past(reset_n) && $past(timer8_cmp_b_en)
      |-> pad_out[ppom_pkg::PIN_CAPTURE] == $past(timer8_cmp_b_out))
      else $error("timer8 compare B not on bit 7");

   AST_SCL_HOLD: assert property ( // R19
      $past(ce) && $past(reset_n) && $past(usi_2w) && $past(usi_scl_hold)
      |-> !pad_oe_n[ppom_pkg::PIN_USI_CLK]
      && !pad_out[ppom_pkg::PIN_USI_CLK])
      else $error("clock stretch does not pull bit 4 low");

   AST_SYNC_DELAY: assert property ( // R13
      ce ##1 ce && $past(reset_n) |-> pin_in_bit == $past(alt_func_input))
      else $error("synchronizer not one flop behind alternate tap");

endmodule

// >>> hw/ppom_pkg.sv
// Purpose: shared constants and types for the port pin override mux
// Assumes: one eight-pin port, one clock
// Notes: override bundles come from the peripheral modules

package ppom_pkg;

   localparam int NUM_PINS = 8;

   // {direction, output bit, global pull-up off} that turns the pull-up on
   localparam logic [2:0] PULLUP_ON_CODE = 3'h2;

   localparam logic DIR_RESET = 1'h0;
   localparam logic OUT_RESET = 1'h0;
   localparam logic OE_N_RESET = 1'h1;
   localparam logic PAD_OUT_RESET = 1'h0;
   localparam logic PULLUP_RESET = 1'h0;
   localparam logic SYNC_RESET = 1'h0;
   localparam logic CLAMP_LEVEL = 1'h0;

   // serial interface wire modes
   localparam logic [1:0] USI_MODE_3W = 2'h1;
   localparam int USI_MODE_2W_BIT = 1;

   // port pin positions of the alternate functions
   localparam int PIN_T8_SRC = 3;
   localparam int PIN_USI_CLK = 4;
   localparam int PIN_USI_DO = 5;
   localparam int PIN_USI_DI = 6;
   localparam int PIN_CAPTURE = 7;

   typedef struct packed {
      logic pullup_ovr_en;
      logic pullup_ovr_val;
      logic dir_ovr_en;
      logic dir_ovr_val;
      logic port_value_ovr_en;
      logic port_value_ovr_val;
      logic port_toggle_ovr_en;
      logic input_en_ovr_en;
      logic input_en_ovr_val;
   } ppom_ovr_t;

endpackage

// >>> hw/ppom_pin_cell.sv
// Purpose: one port pin: registers, override selection, clamp, synchronizer
// Assumes: pad inputs synchronous to clock
// Notes: pad controls are registered, so they trail their causes one cycle

`timescale 1ns/1ns

module ppom_pin_cell
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic wdata,
   input wire logic dir_write,
   input wire logic out_write,
   input wire logic pin_write,
   input wire logic sleep_clamp,
   input wire logic pullup_global_off,
   input wire logic ext_int_en,
   input wire ppom_pkg::ppom_ovr_t ovr,
   input wire logic pad_in,
   output logic dir_bit,
   output logic out_bit,
   output logic pin_in_bit,
   output logic alt_in,
   output logic pad_out,
   output logic pad_oe_n,
   output logic pullup_en
);

   logic pu_default;
   logic pu_next;
   logic drv_en;
   logic drv_val;
   logic din_en_sleep;
   logic din_en;
   logic schmitt_in;
   logic toggle;
   logic out_next;
   logic sync1_reg;

   assign pu_default = {dir_bit, out_bit, pullup_global_off}
      == ppom_pkg::PULLUP_ON_CODE; // R4
   assign pu_next = ovr.pullup_ovr_en ? ovr.pullup_ovr_val
      : pu_default; // R5
   assign drv_en = ovr.dir_ovr_en ? ovr.dir_ovr_val : dir_bit; // R6 R7 R23
   assign drv_val = ovr.port_value_ovr_en ? ovr.port_value_ovr_val
      : out_bit; // R8 R9
   // clamp only in deep sleep, interrupt pins keep listening
   assign din_en_sleep = ~sleep_clamp | ext_int_en; // R1 R2 R16
   assign din_en = ovr.input_en_ovr_en ? ovr.input_en_ovr_val
      : din_en_sleep; // R11 R12
   assign schmitt_in = din_en ? pad_in : ppom_pkg::CLAMP_LEVEL; // R26
   assign toggle = (pin_write & wdata) | ovr.port_toggle_ovr_en; // R10 R24
   assign out_next = (out_write ? wdata : out_bit) ^ toggle;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         dir_bit <= ppom_pkg::DIR_RESET;
         out_bit <= ppom_pkg::OUT_RESET;
         pad_oe_n <= ppom_pkg::OE_N_RESET; // R25
         pad_out <= ppom_pkg::PAD_OUT_RESET;
         pullup_en <= ppom_pkg::PULLUP_RESET; // R17
         sync1_reg <= ppom_pkg::SYNC_RESET;
         pin_in_bit <= ppom_pkg::SYNC_RESET;
         alt_in <= ppom_pkg::SYNC_RESET;
      end
      else if (ce)
      begin
         dir_bit <= dir_write ? wdata : dir_bit;
         out_bit <= out_next;
         pad_oe_n <= ~drv_en;
         pad_out <= drv_val;
         pullup_en <= pu_next;
         sync1_reg <= schmitt_in;
         pin_in_bit <= sync1_reg;
         // single stage only, consumers add their own synchronizer
         alt_in <= schmitt_in; // R13
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   AST_PULLUP_OVR: assert property ( // R5
      $past(ce) && $past(reset_n) && $past(ovr.pullup_ovr_en)
      |-> pullup_en == $past(ovr.pullup_ovr_val))
      else $error("pull-up does not follow override value");

   AST_PULLUP_DEFAULT: assert property ( // R4
      $past(ce) && $past(reset_n) && !$past(ovr.pullup_ovr_en)
      |-> pullup_en == ($past({dir_bit, out_bit, pullup_global_off})
      == ppom_pkg::PULLUP_ON_CODE))
      else $error("pull-up wrong for register bits");

   AST_DRIVER_EN: assert property ( // R6
      $past(ce) && $past(reset_n)
      |-> !pad_oe_n == ($past(ovr.dir_ovr_en) ? $past(ovr.dir_ovr_val)
      : $past(dir_bit)))
      else $error("driver enable from wrong source");

   AST_PORT_VALUE: assert property ( // R8
      $past(ce) && $past(reset_n) && $past(ovr.port_value_ovr_en)
      |-> pad_out == $past(ovr.port_value_ovr_val))
      else $error("pad value ignores override");

   AST_TOGGLE: assert property ( // R10
      $past(ce) && $past(reset_n) && $past(ovr.port_toggle_ovr_en)
      && !$past(out_write) && !($past(pin_write) && $past(wdata))
      |-> out_bit != $past(out_bit))
      else $error("toggle override did not invert output bit");

   AST_PIN_WRITE_TOGGLE: assert property ( // R24
      $past(ce) && $past(reset_n) && $past(pin_write) && $past(wdata)
      && !$past(out_write) && !$past(ovr.port_toggle_ovr_en)
      |-> out_bit != $past(out_bit))
      else $error("pin write of one did not invert output bit");

   AST_CLAMP: assert property ( // R1
      $past(ce) && $past(reset_n) && $past(sleep_clamp)
      && !$past(ext_int_en) && !$past(ovr.input_en_ovr_en)
      |-> alt_in == ppom_pkg::CLAMP_LEVEL)
      else $error("clamped input not low");

   AST_INPUT_OVR_OFF: assert property ( // R12
      $past(ce) && $past(reset_n) && $past(ovr.input_en_ovr_en)
      && !$past(ovr.input_en_ovr_val)
      |-> alt_in == ppom_pkg::CLAMP_LEVEL)
      else $error("input passes while override disables it");

   AST_RESET_PULLUP: assert property ( // R17
      !$past(reset_n) |-> !pullup_en && pad_oe_n)
      else $error("pull-up or driver on after reset");

endmodule

// >>> test/ppom_pad_model.sv
// Purpose: pad and outside-world model for the eight port pins
// Assumes: outside drivers act only where ext_drive_en is set
// Notes: a floating pin shows the inverse of its last level

`timescale 1ns/1ns

module ppom_pad_model
(
   input wire logic clock,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] pad_pullup_en,
   input wire logic [7:0] ext_drive_en,
   input wire logic [7:0] ext_level,
   output logic [7:0] pad_in
);
   logic [7:0] last_reg = 8'h00;

   // floating level keeps moving so a stale value never passes
   always_comb
   begin
      for (int k = 0; k < 8; k++)
      begin
         if (!pad_oe_n[k])
            pad_in[k] = pad_out[k];
         else if (ext_drive_en[k])
            pad_in[k] = ext_level[k];
         else if (pad_pullup_en[k])
            pad_in[k] = 1'h1;
         else
            pad_in[k] = ~last_reg[k];
      end
   end

   always_ff @(posedge clock)
      last_reg <= pad_in;
endmodule

// >>> test/port_pin_override_mux_tb_top.sv
// Purpose: self-checking bench for the port pin override mux
// Assumes: pad outputs trail their causes by one edge
// Notes: generic overrides only on pins 0..3, peripherals own 4..7

`timescale 1ns/1ns

module port_pin_override_mux_tb_top;
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic ce = 1'h1;
   logic [7:0] wdata = 8'h00;
   logic dir_write = 1'h0, out_write = 1'h0, pin_write = 1'h0;
   logic sleep_clamp = 1'h0, pullup_global_off = 1'h0;
   ppom_pkg::ppom_ovr_t [7:0] ovr_in = '0;
   logic [7:0] ext_int_en = 8'h00, ext_int_edge_mode = 8'h00;
   logic [1:0] usi_wire_mode = 2'h0;
   logic usi_data_out_3w = 1'h0, usi_sda_out = 1'h0, usi_scl_hold = 1'h0;
   logic timer16_cmp_a_en = 1'h0, timer16_cmp_a_out = 1'h0;
   logic timer16_cmp_b_en = 1'h0, timer16_cmp_b_out = 1'h0;
   logic timer8_cmp_b_en = 1'h0, timer8_cmp_b_out = 1'h0;
   logic [7:0] ext_drive_en = 8'h00, ext_level = 8'h00, pad_in;
   logic [7:0] pad_out, pad_oe_n, pad_pullup_en, dir_bit, out_bit;
   logic [7:0] pin_in_bit, alt_func_input, pin_change_src, wake;
   logic usi_clock_3w, usi_clock_2w, usi_data_in_3w, usi_sda_in;
   logic timer8_count_src, timer16_count_src, timer16_capture_in;
   logic [31:0] seed = 32'h00000027;
   int error_cnt = 0;
   int num_checks = 0;

   ppom_port u_ppom_port (.clock(clock), .reset_n(reset_n), .ce(ce),
      .reg_write_data(wdata), .dir_write(dir_write),
      .out_write(out_write), .pin_write(pin_write),
      .sleep_clamp(sleep_clamp), .pullup_global_off(pullup_global_off),
      .ovr_in(ovr_in), .ext_int_en(ext_int_en),
      .ext_int_edge_mode(ext_int_edge_mode), .usi_wire_mode(usi_wire_mode),
      .usi_data_out_3w(usi_data_out_3w), .usi_sda_out(usi_sda_out),
      .usi_scl_hold(usi_scl_hold), .timer16_cmp_a_en(timer16_cmp_a_en),
      .timer16_cmp_a_out(timer16_cmp_a_out),
      .timer16_cmp_b_en(timer16_cmp_b_en),
      .timer16_cmp_b_out(timer16_cmp_b_out),
      .timer8_cmp_b_en(timer8_cmp_b_en), .timer8_cmp_b_out(timer8_cmp_b_out),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup_en(pad_pullup_en), .dir_bit(dir_bit), .out_bit(out_bit),
      .pin_in_bit(pin_in_bit), .alt_func_input(alt_func_input),
      .pin_change_src(pin_change_src), .usi_clock_3w(usi_clock_3w),
      .usi_clock_2w(usi_clock_2w), .usi_data_in_3w(usi_data_in_3w),
      .usi_sda_in(usi_sda_in), .timer8_count_src(timer8_count_src),
      .timer16_count_src(timer16_count_src),
      .timer16_capture_in(timer16_capture_in), .ext_int_wake_flag(wake));

   ppom_pad_model u_ppom_pad_model (.clock(clock), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
      .ext_drive_en(ext_drive_en), .ext_level(ext_level), .pad_in(pad_in));

   initial
   begin
      forever #5 clock = ~clock;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // extra idle edge so a strobe is never raised in the step it drops
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      {dir_write, out_write, pin_write} = sel;
      wdata = d;
      tick(1);
      {dir_write, out_write, pin_write} = 3'h0;
      tick(1);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic t_out();
      logic [31:0] r, q;
      logic [7:0] d, o, drv, ep, pu;
      for (int i = 0; i < 24; i++)
      begin
         r = rnd();
         d = r[7:0];
         o = r[15:8];
         pullup_global_off = r[16];
         for (int k = 0; k < 8; k++)
         begin
            q = rnd();
            ovr_in[k] = (k < 4 && i > 0) ? q[8:0] & 9'h1FB : 9'h000;
         end
         wr(3'h4, d);
         wr(3'h2, o);
         for (int k = 0; k < 8; k++)
         begin
            drv[k] = ovr_in[k].dir_ovr_en ? ovr_in[k].dir_ovr_val : d[k];
            ep[k] = ovr_in[k].port_value_ovr_en ?
                    ovr_in[k].port_value_ovr_val : o[k];
            pu[k] = ovr_in[k].pullup_ovr_en ? ovr_in[k].pullup_ovr_val :
                    ({d[k], o[k], pullup_global_off} ==
                     ppom_pkg::PULLUP_ON_CODE);
         end
         chk("dir_bit", d, dir_bit);
         chk("out_bit", o, out_bit);
         chk("pad_oe_n", ~drv, pad_oe_n);
         chk("pad_out", ep & drv, pad_out & drv);
         chk("pad_pullup_en", pu, pad_pullup_en);
      end
      ovr_in = '0;
      $display("test output paths done");
   endtask

   task automatic t_in();
      logic [31:0] r, q;
      logic [7:0] e;
      logic ie;
      wr(3'h4, 8'h00);
      wr(3'h2, 8'h00);
      ext_drive_en = 8'hFF;
      for (int i = 0; i < 16; i++)
      begin
         r = rnd();
         ext_level = (i == 0) ? 8'hFF : r[7:0];
         ext_int_en = (i == 0) ? 8'h00 : r[15:8];
         sleep_clamp = (i == 0) ? 1'h1 : r[16];
         for (int k = 0; k < 8; k++)
         begin
            q = rnd();
            ovr_in[k] = (k < 4) ? {7'h00, q[1:0]} : 9'h000;
         end
         tick(3);
         for (int k = 0; k < 8; k++)
         begin
            ie = ovr_in[k].input_en_ovr_en ? ovr_in[k].input_en_ovr_val :
                 (!sleep_clamp || ext_int_en[k]);
            e[k] = ie & ext_level[k];
         end
         chk("alt_func_input", e, alt_func_input);
         chk("pin_in_bit", e, pin_in_bit);
         chk("pin_change_src", e, pin_change_src);
         chk("alt_map", {1'h0, e[7], e[6], e[6], e[4], e[4], e[4], e[3]},
             {1'h0, timer16_capture_in, usi_sda_in, usi_data_in_3w,
              timer16_count_src, usi_clock_2w, usi_clock_3w,
              timer8_count_src});
      end
      sleep_clamp = 1'h0;
      ovr_in = '0;
      ext_level = 8'h00;
      tick(3);
      ext_level = 8'h81;
      tick(1);
      chk("alt_func_input", 8'h81, alt_func_input);
      chk("pin_in_bit", 8'h00, pin_in_bit);
      tick(1);
      chk("pin_in_bit", 8'h81, pin_in_bit);
      ext_int_edge_mode = 8'hFF;
      ext_int_en = 8'h0F;
      ext_level = 8'hAA;
      sleep_clamp = 1'h1;
      tick(2);
      sleep_clamp = 1'h0;
      tick(1);
      chk("ext_int_wake_flag", 8'hA0, wake);
      tick(1);
      chk("ext_int_wake_flag", 8'h00, wake);
      ext_int_edge_mode = 8'h00;
      ext_int_en = 8'h00;
      ext_drive_en = 8'h00;
      $display("test input paths done");
   endtask

   task automatic t_toggle();
      wr(3'h2, 8'h0F);
      wr(3'h1, 8'h3C);
      chk("out_bit", 8'h33, out_bit);
      wr(3'h3, 8'h55);
      chk("out_bit", 8'h00, out_bit);
      ovr_in[2].port_toggle_ovr_en = 1'h1;
      tick(1);
      ovr_in[2].port_toggle_ovr_en = 1'h0;
      tick(1);
      chk("out_bit", 8'h04, out_bit);
      ce = 1'h0;
      wr(3'h2, 8'hFF);
      ce = 1'h1;
      chk("out_bit", 8'h04, out_bit);
      $display("test toggle done");
   endtask

   task automatic t_periph();
      logic [31:0] r;
      wr(3'h4, 8'hFF);
      wr(3'h2, 8'h00);
      {timer16_cmp_a_en, timer16_cmp_b_en, timer8_cmp_b_en} = 3'h7;
      for (int i = 0; i < 10; i++)
      begin
         r = rnd();
         {timer16_cmp_a_out, timer16_cmp_b_out, timer8_cmp_b_out} = r[2:0];
         usi_data_out_3w = r[3];
         usi_wire_mode = {1'h0, r[4]};
         tick(2);
         chk("pad_oe_n", 8'h00, pad_oe_n);
         chk("pad_out", {r[0], r[2], r[4] ? r[3] : r[1], 5'h00},
             pad_out);
      end
      usi_wire_mode = 2'h2;
      usi_scl_hold = 1'h1;
      usi_sda_out = r[5];
      tick(2);
      chk("pad_oe_n_2w", 8'h00, pad_oe_n & 8'h50);
      chk("pad_out_2w", 8'h00, pad_out & 8'h50);
      usi_wire_mode = 2'h0;
      usi_scl_hold = 1'h0;
      {timer16_cmp_a_en, timer16_cmp_b_en, timer8_cmp_b_en} = 3'h0;
      $display("test peripherals done");
   endtask

   task automatic t_reset();
      pullup_global_off = 1'h0;
      wr(3'h4, 8'h02);
      wr(3'h2, 8'h01);
      chk("pad_pullup_en", 8'h01, pad_pullup_en);
      reset_n = 1'h0;
      tick(1);
      chk("pad_oe_n", 8'hFF, pad_oe_n);
      chk("pad_pullup_en", 8'h00, pad_pullup_en);
      chk("out_bit", 8'h00, out_bit);
      tick(2);
      reset_n = 1'h1;
      tick(1);
      $display("test reset done");
   endtask

   initial
   begin
      repeat (16) @(posedge clock);
      #1;
      chk("pad_oe_n", 8'hFF, pad_oe_n);
      chk("pad_pullup_en", 8'h00, pad_pullup_en);
      reset_n = 1'h1;
      tick(1);
      t_out();
      t_in();
      t_toggle();
      t_periph();
      t_reset();
      complete_run();
   end

   // whole run is near 220 cycles; allow about forty-five times that
   initial
   begin
      #100000;
      error_cnt++;
      complete_run();
   end
endmodule
